//--- logic/etp_top.sv
// Purpose: pair of eight-bit pwm timers behind an axi4-lite slave
// Assumes: src_in and cmp_in are asynchronous to clk_sys
// Notes: source edges must be slower than half of clk_sys
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "etp_consts.svh"
module etp_top #(
   parameter int ADDR_W = 8,
   parameter int NUM_SRC = 16,
   parameter bit SEVEN_BIT_OPT = 1'b0,
   parameter bit CMP_GATE_OPT = 1'b0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // clock sources and comparator
   input wire logic [NUM_SRC-1:0] src_in,
   input wire logic cmp_in,
   // pins: three routes per timer
   output logic [5:0] pin_o,
   output logic [5:0] pin_oe_n
);
   import etp_pkg::*;

   etp_ctrl_t ctrl_reg [2];
   logic [7:0] bound_reg [2];
   etp_scal_t scal_reg [2];
   logic [7:0] cnt_val [2];
   logic [1:0] pwm_out;
   logic [1:0] cnt_wr;
   logic [1:0] src_tick;

   // ======================================================
   // input synchronisers
   logic [NUM_SRC-1:0] src_s1_reg;
   logic [NUM_SRC-1:0] src_s2_reg;
   logic [NUM_SRC-1:0] src_s3_reg;
   logic [NUM_SRC-1:0] tick_vec;
   logic cmp_s1_reg;
   logic cmp_s2_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         src_s1_reg <= '0;
         src_s2_reg <= '0;
         src_s3_reg <= '0;
      end else begin
         src_s1_reg <= src_in;
         src_s2_reg <= src_s1_reg;
         src_s3_reg <= src_s2_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cmp_s1_reg <= 1'b0;
         cmp_s2_reg <= 1'b0;
      end else begin
         cmp_s1_reg <= cmp_in;
         cmp_s2_reg <= cmp_s1_reg;
      end
   end

   // code 0 stops the timer, code 1 is the system clock itself
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
         if (gi == 0) begin : g_stop
            assign tick_vec[gi] = 1'b0;
         end else if (gi == 1) begin : g_sys
            assign tick_vec[gi] = 1'b1;
         end else begin : g_pin
            assign tick_vec[gi] = src_s2_reg[gi] && !src_s3_reg[gi];
         end
      end
   endgenerate

   // ======================================================
   // write channel
   logic aw_full_reg;
   logic w_full_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_lane0_reg;
   logic do_wr;
   logic wr_hit;
   logic wr_timer;
   logic [1:0] wr_kind;

   assign wr_timer = aw_addr_reg[`ETP_ADDR_TIMER_BIT];
   assign wr_kind = aw_addr_reg[3:2];
   assign wr_hit = (aw_addr_reg[ADDR_W-1:5] == '0) && (aw_addr_reg[1:0] == 2'h0);
   assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         aw_full_reg <= 1'b0;
         s_axi_awready <= 1'b1;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_reg <= 1'b1;
         s_axi_awready <= 1'b0;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_full_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         w_full_reg <= 1'b0;
         s_axi_wready <= 1'b1;
         w_data_reg <= 8'h00;
         w_lane0_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_reg <= 1'b1;
         s_axi_wready <= 1'b0;
         w_data_reg <= s_axi_wdata[7:0];
         w_lane0_reg <= s_axi_wstrb[0];
      end else if (do_wr) begin
         w_full_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ETP_RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `ETP_RESP_OKAY : `ETP_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ======================================================
   // registers, one set per timer
   generate
      for (gi = 0; gi < 2; gi++) begin : g_tmr
         logic sel;
         assign sel = do_wr && wr_hit && w_lane0_reg && (wr_timer == gi[0]);
         assign cnt_wr[gi] = sel && (wr_kind == `ETP_KIND_CNT);

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               ctrl_reg[gi] <= etp_ctrl_t'(`ETP_CTRL_RST);
            end else if (sel && wr_kind == `ETP_KIND_CTRL) begin
               ctrl_reg[gi] <= etp_ctrl_t'(w_data_reg);
            end
         end

         // no guard against mid-period bound writes; software waits for zero
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               bound_reg[gi] <= `ETP_BOUND_RST;
            end else if (sel && wr_kind == `ETP_KIND_BOUND) begin
               bound_reg[gi] <= w_data_reg;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               scal_reg[gi] <= etp_scal_t'(`ETP_SCAL_RST);
            end else if (sel && wr_kind == `ETP_KIND_SCAL) begin
               scal_reg[gi] <= etp_scal_t'(w_data_reg);
            end
         end

         assign src_tick[gi] = tick_vec[ctrl_reg[gi].clk_sel];

         etp_timer #(
            .SEVEN_BIT_OPT(SEVEN_BIT_OPT),
            .CMP_GATE_OPT(CMP_GATE_OPT)
         ) u_timer (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .ctrl(ctrl_reg[gi]),
            .bound(bound_reg[gi]),
            .scal(scal_reg[gi]),
            .src_tick(src_tick[gi]),
            .cmp_hi(cmp_s2_reg),
            .cnt_wr(cnt_wr[gi]),
            .cnt_wdata(w_data_reg),
            .cnt_reg(cnt_val[gi]),
            .out_reg(pwm_out[gi])
         );

         // pin forced to drive whenever routed, direction ignored
         for (genvar gj = 0; gj < 3; gj++) begin : g_pin
            always_ff @(posedge clk_sys) begin
               if (!rst_n) begin
                  pin_o[gi*3+gj] <= 1'b0;
                  pin_oe_n[gi*3+gj] <= 1'b1;
               end else begin
                  pin_o[gi*3+gj] <= (ctrl_reg[gi].route == 2'(gj + 1)) && pwm_out[gi];
                  pin_oe_n[gi*3+gj] <= (ctrl_reg[gi].route != 2'(gj + 1));
               end
            end
         end
      end
   endgenerate

   // ======================================================
   // read channel
   logic rd_hit;
   logic rd_timer;
   logic [7:0] rd_byte;

   assign rd_timer = s_axi_araddr[`ETP_ADDR_TIMER_BIT];
   assign rd_hit = (s_axi_araddr[ADDR_W-1:5] == '0) && (s_axi_araddr[1:0] == 2'h0);

   always_comb begin
      case (s_axi_araddr[3:2])
         `ETP_KIND_CTRL: rd_byte = ctrl_reg[rd_timer];
         `ETP_KIND_BOUND: rd_byte = bound_reg[rd_timer];
         `ETP_KIND_SCAL: rd_byte = scal_reg[rd_timer];
         default: rd_byte = cnt_val[rd_timer];
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ETP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         s_axi_rresp <= rd_hit ? `ETP_RESP_OKAY : `ETP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ======================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   pin_route_a: assert property (
      (ctrl_reg[0].route == 2'h1) |=> (!pin_oe_n[0] && pin_o[0] == $past(pwm_out[0])))
      else $error("routed pin not driven by timer output");
   pin_idle_a: assert property (
      (ctrl_reg[1].route == `ETP_ROUTE_NONE) |=> (pin_oe_n[5:3] == 3'h7))
      else $error("unrouted pins driven");
   src_stop_a: assert property (
      (ctrl_reg[0].clk_sel == `ETP_SRC_STOP && !cnt_wr[0]) |=> $stable(cnt_val[0]))
      else $error("stopped timer counted");
   bound_wr_a: assert property (
      (do_wr && wr_hit && w_lane0_reg && wr_kind == `ETP_KIND_BOUND)
      |=> (bound_reg[$past(wr_timer)] == $past(w_data_reg)))
      else $error("bound write lost");
   wr_resp_a: assert property (
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after the pair");
   rd_resp_a: assert property (
      (s_axi_arvalid && s_axi_arready) |=> (s_axi_rvalid && !s_axi_arready))
      else $error("read answer not one cycle after address");

   pair_run_c: cover property (ctrl_reg[1].invert && ctrl_reg[0].pwm_mode
                               && ctrl_reg[1].pwm_mode);
   wr_done_c: cover property (s_axi_bvalid && s_axi_bready);
   bad_addr_c: cover property (s_axi_rvalid && s_axi_rresp == `ETP_RESP_SLVERR);
endmodule : etp_top

//--- logic/etp_consts.svh
// Purpose: constants for the eight-bit pwm timer pair
// Assumes: byte addresses on an axi4-lite bus, 32-bit data
// Notes: byte address = {timer, kind, 2'b00}
`ifndef ETP_CONSTS_SVH
`define ETP_CONSTS_SVH

// ======================================================
// register map
`define ETP_ADDR_TIMER_BIT 4
`define ETP_KIND_CTRL 2'h0
`define ETP_KIND_BOUND 2'h1
`define ETP_KIND_SCAL 2'h2
`define ETP_KIND_CNT 2'h3

// ======================================================
// reset values
`define ETP_CTRL_RST 8'h00
`define ETP_BOUND_RST 8'h00
`define ETP_SCAL_RST 8'h00
`define ETP_CNT_RST 8'h00

// ======================================================
// field codes
`define ETP_SRC_STOP 4'h0
`define ETP_SRC_SYS 4'h1
`define ETP_ROUTE_NONE 2'h0
`define ETP_PRE_LIM0 6'h00
`define ETP_PRE_LIM1 6'h03
`define ETP_PRE_LIM2 6'h0f
`define ETP_PRE_LIM3 6'h3f
`define ETP_PER_MAX8 8'hff
`define ETP_PER_MAX7 8'h7f
`define ETP_PER_MAX6 8'h3f

// ======================================================
// bus answers
`define ETP_RESP_OKAY 2'h0
`define ETP_RESP_SLVERR 2'h2

`endif

//--- logic/etp_pkg.sv
// Purpose: types shared by the pwm timer files
// Assumes: nothing
// Notes: field layouts of the software registers
package etp_pkg;
   // ======================================================
   // control register: [7:4] source, [3:2] pin route, [1] pwm, [0] invert
   typedef struct packed {
      logic [3:0] clk_sel;
      logic [1:0] route;
      logic pwm_mode;
      logic invert;
   } etp_ctrl_t;

   // scaler register: [7] reduced resolution, [6:5] prescale, [4:0] divider
   typedef struct packed {
      logic reduced;
      logic [1:0] prescale;
      logic [4:0] div;
   } etp_scal_t;
endpackage : etp_pkg

//--- logic/etp_timer.sv
// Purpose: one eight-bit up-counting timer with pwm and period output
// Assumes: src_tick is a one-cycle pulse per source edge on clk_sys
// Notes: out_reg already carries the inversion and the comparator gate
`timescale 1ns/1ps
`include "etp_consts.svh"
module etp_timer #(
   parameter bit SEVEN_BIT_OPT = 1'b0,
   parameter bit CMP_GATE_OPT = 1'b0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // settings
   input etp_pkg::etp_ctrl_t ctrl,
   input wire logic [7:0] bound,
   input etp_pkg::etp_scal_t scal,
   // events
   input wire logic src_tick,
   input wire logic cmp_hi,
   input wire logic cnt_wr,
   input wire logic [7:0] cnt_wdata,
   // results
   output logic [7:0] cnt_reg,
   output logic out_reg
);
   import etp_pkg::*;

   logic [5:0] pre_reg;
   logic [4:0] div_reg;
   logic tog_reg;
   logic [5:0] pre_lim;
   logic [7:0] per_max;
   logic pre_done;
   logic scaled_tick;
   logic pwm_level;
   logic gate_now;
   logic raw;

   // ======================================================
   // prescaler and scaler
   always_comb begin
      case (scal.prescale)
         2'h0: pre_lim = `ETP_PRE_LIM0;
         2'h1: pre_lim = `ETP_PRE_LIM1;
         2'h2: pre_lim = `ETP_PRE_LIM2;
         default: pre_lim = `ETP_PRE_LIM3;
      endcase
   end
   // >= so that shrinking a limit mid-count never runs the counter round
   assign pre_done = src_tick && (pre_reg >= pre_lim);
   assign scaled_tick = pre_done && (div_reg >= scal.div);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pre_reg <= 6'h00;
      end else if (src_tick) begin
         pre_reg <= pre_done ? 6'h00 : pre_reg + 6'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         div_reg <= 5'h00;
      end else if (pre_done) begin
         div_reg <= scaled_tick ? 5'h00 : div_reg + 5'h01;
      end
   end

   // ======================================================
   // counter
   always_comb begin
      if (!scal.reduced) begin
         per_max = `ETP_PER_MAX8;
      end else if (SEVEN_BIT_OPT) begin
         per_max = `ETP_PER_MAX7;
      end else begin
         per_max = `ETP_PER_MAX6;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_reg <= `ETP_CNT_RST;
      end else if (cnt_wr) begin
         cnt_reg <= cnt_wdata;
      end else if (scaled_tick) begin
         if (ctrl.pwm_mode) begin
            cnt_reg <= (cnt_reg >= per_max) ? 8'h00 : cnt_reg + 8'h01;
         end else begin
            cnt_reg <= (cnt_reg >= bound) ? 8'h00 : cnt_reg + 8'h01;
         end
      end
   end

   // period mode: half period per bound match
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tog_reg <= 1'b0;
      end else if (scaled_tick && !ctrl.pwm_mode && (cnt_reg >= bound)) begin
         tog_reg <= !tog_reg;
      end
   end

   // ======================================================
   // output
   // bound at or above the period top keeps the level high throughout
   assign pwm_level = (cnt_reg <= bound);
   assign gate_now = CMP_GATE_OPT && cmp_hi;
   assign raw = ctrl.pwm_mode ? pwm_level : tog_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         out_reg <= 1'b0;
      end else begin
         out_reg <= (gate_now ? 1'b0 : raw) ^ ctrl.invert;
      end
   end

   // ======================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   full_duty_8_a: assert property (
      (ctrl.pwm_mode && !scal.reduced && bound == 8'hff && !gate_now)
      |=> (out_reg != $past(ctrl.invert)))
      else $error("full duty in 8-bit mode not high");
   full_duty_6_a: assert property (
      (ctrl.pwm_mode && scal.reduced && !SEVEN_BIT_OPT && bound == 8'h3f && !gate_now)
      |=> (out_reg != $past(ctrl.invert)))
      else $error("full duty in 6-bit mode not high");
   wrap_eight_a: assert property (
      (scaled_tick && ctrl.pwm_mode && !scal.reduced && cnt_reg == 8'hff && !cnt_wr)
      |=> (cnt_reg == 8'h00))
      else $error("8-bit counter did not wrap after 255");
   wrap_reduced_a: assert property (
      (scaled_tick && ctrl.pwm_mode && scal.reduced && !cnt_wr
       && cnt_reg == (SEVEN_BIT_OPT ? 8'h7f : 8'h3f))
      |=> (cnt_reg == 8'h00))
      else $error("reduced counter did not wrap at its top");
   count_hold_a: assert property (
      (!scaled_tick && !cnt_wr) |=> $stable(cnt_reg))
      else $error("counter moved without a scaled tick");
   duty_high_a: assert property (
      (ctrl.pwm_mode && cnt_reg <= bound && !gate_now)
      |=> (out_reg != $past(ctrl.invert)))
      else $error("output low inside the duty window");
   duty_low_a: assert property (
      (ctrl.pwm_mode && cnt_reg > bound && !gate_now)
      |=> (out_reg == $past(ctrl.invert)))
      else $error("output high past the duty bound");
   gate_off_a: assert property (
      gate_now |=> (out_reg == $past(ctrl.invert)))
      else $error("output not suppressed by comparator");
   cnt_load_a: assert property (
      cnt_wr |=> (cnt_reg == $past(cnt_wdata)))
      else $error("counter write not taken");

   wrap_seen_c: cover property (scaled_tick && ctrl.pwm_mode && cnt_reg == per_max);
   gate_seen_c: cover property (gate_now && ctrl.pwm_mode);
endmodule : etp_timer

//--- verif/tb_top.sv
// Purpose: self-checking bench for the pwm timer pair behind axi4-lite
// Assumes: 40 MHz clk_sys, synchronous active-low reset
// Notes: a second instance with the seven-bit option shares the bus inputs
`timescale 1ns/1ps
`include "etp_consts.svh"
module tb_top;
   import etp_pkg::*;
   // ======================================================
   // signals
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'h0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'h0;
   logic [15:0] src_in = 16'h0;
   logic cmp_in = 1'h0;
   logic [5:0] pin_o;
   logic [5:0] pin_oe_n;
   logic [5:0] pin_b;
   logic [11:0] pins;
   logic [2:0] src_div = 3'h0;
   int num_errors = 0;
   int n_compared = 0;

   assign pins = {pin_b, pin_o};
   always #12.5 clk_sys = ~clk_sys;
   // external source: one rising edge every 8 clocks
   always @(posedge clk_sys) begin
      src_div <= src_div + 3'h1;
      src_in[2] <= src_div[2];
   end

   // ======================================================
   // devices
   etp_top #(.CMP_GATE_OPT(1'h1)) etp_top_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .src_in(src_in),
      .cmp_in(cmp_in), .pin_o(pin_o), .pin_oe_n(pin_oe_n));
   // same bus traffic, only its pins are judged
   etp_top #(.SEVEN_BIT_OPT(1'h1)) etp_top_i_b (.clk_sys(clk_sys), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
      .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
      .src_in(src_in), .cmp_in(cmp_in), .pin_o(pin_b), .pin_oe_n());

   // ======================================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      forever begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'h0;
            break;
         end
      end
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      forever begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'h0;
            break;
         end
      end
   endtask : axr

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axw(a, d, r);
      chk("write response", `ETP_RESP_OKAY, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      chk("read response", er, r);
      chk("read data", e, d);
   endtask : rd

   // skips two edges so the period measured runs wholly under the new setting
   task automatic measure(input int k, input bit inv, input int e_hi, input int e_per);
      int hi = 0;
      int per = 0;
      repeat (2) begin
         while ((pins[k] ^ inv) !== 1'h0) @(posedge clk_sys);
         while ((pins[k] ^ inv) !== 1'h1) @(posedge clk_sys);
      end
      while ((pins[k] ^ inv) === 1'h1) begin
         hi++;
         @(posedge clk_sys);
      end
      per = hi;
      while ((pins[k] ^ inv) === 1'h0) begin
         per++;
         @(posedge clk_sys);
      end
      chk("high time", e_hi, hi);
      chk("period", e_per, per);
   endtask : measure

   task automatic steady(input int k, input logic lvl, input int cyc);
      int bad = 0;
      repeat (cyc) begin
         @(posedge clk_sys);
         if (pins[k] !== lvl) bad++;
      end
      chk("steady level", 0, bad);
   endtask : steady

   // a running pair is retuned only from a stopped, zeroed counter
   task automatic pair_bounds(input logic [7:0] b);
      wr(8'h00, 8'h06);
      wr(8'h10, 8'h07);
      wr(8'h0c, 8'h00);
      wr(8'h1c, 8'h00);
      wr(8'h04, b);
      wr(8'h14, b);
      wr(8'h00, 8'h16);
      wr(8'h10, 8'h17);
   endtask : pair_bounds

   // ======================================================
   // scenarios
   task automatic t_regs();
      logic [1:0] r;
      for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0, `ETP_RESP_OKAY);
      chk("pin enables idle", 6'h3f, pin_oe_n);
      wr(8'h14, 8'ha5);
      rd(8'h14, 32'ha5, `ETP_RESP_OKAY);
      // lane 0 not strobed: answered but not written
      s_axi_wstrb <= 4'h0;
      wr(8'h14, 8'h3c);
      s_axi_wstrb <= 4'hf;
      rd(8'h14, 32'ha5, `ETP_RESP_OKAY);
      rd(8'h20, 32'h0, `ETP_RESP_SLVERR);
      axw(8'h22, 8'h11, r);
      chk("unmapped write", `ETP_RESP_SLVERR, r);
   endtask : t_regs

   task automatic t_pwm8();
      wr(8'h04, 8'h09);
      wr(8'h14, 8'h09);
      wr(8'h00, 8'h16);
      wr(8'h10, 8'h17);
      measure(0, 1'h0, 10, 256);
      measure(3, 1'h1, 10, 256);
      chk("pin enables routed", 6'h36, pin_oe_n);
   endtask : t_pwm8

   task automatic t_full_gate();
      pair_bounds(8'hff);
      steady(0, 1'h1, 600);
      @(posedge clk_sys) cmp_in <= 1'h1;
      repeat (6) @(posedge clk_sys);
      steady(0, 1'h0, 300);
      chk("gated inverted pin", 1'h1, pin_o[3]);
      @(posedge clk_sys) cmp_in <= 1'h0;
      repeat (6) @(posedge clk_sys);
      steady(0, 1'h1, 100);
   endtask : t_full_gate

   task automatic t_reduced();
      // pair dissolved first, so timer 0 alone may be retuned mid-count
      wr(8'h10, 8'h00);
      wr(8'h04, 8'h1f);
      wr(8'h08, 8'h80);
      measure(0, 1'h0, 32, 64);
      measure(6, 1'h0, 32, 128);
      for (int p = 1; p < 4; p++) begin
         wr(8'h08, 8'h80 | 8'(p << 5));
         measure(0, 1'h0, 32 << (2 * p), 64 << (2 * p));
      end
      wr(8'h08, 8'h9f);
      measure(0, 1'h0, 32 * 32, 64 * 32);
      wr(8'h08, 8'h80);
      wr(8'h04, 8'h3f);
      // new bound reaches the pin two clocks after the write lands
      repeat (3) @(posedge clk_sys);
      steady(0, 1'h1, 200);
   endtask : t_reduced

   task automatic t_source_count();
      logic [31:0] c1;
      logic [31:0] c2;
      logic [1:0] r;
      wr(8'h04, 8'h1f);
      wr(8'h00, 8'h26);
      measure(0, 1'h0, 32 * 8, 64 * 8);
      wr(8'h00, 8'h06);
      wr(8'h0c, 8'h5a);
      repeat (50) @(posedge clk_sys);
      rd(8'h0c, 32'h5a, `ETP_RESP_OKAY);
      wr(8'h08, 8'h00);
      wr(8'h00, 8'h16);
      axr(8'h0c, c1, r);
      axr(8'h0c, c2, r);
      chk("counter steps up", 1'h1, (c2[7:0] - c1[7:0]) inside {[8'h01 : 8'h10]});
      // period mode: counter runs 0..bound and the level flips at each wrap
      wr(8'h04, 8'h09);
      wr(8'h00, 8'h14);
      measure(0, 1'h0, 10, 20);
   endtask : t_source_count

   // ======================================================
   // run control
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      t_regs();
      t_pwm8();
      t_full_gate();
      t_reduced();
      t_source_count();
      final_report();
   end

   // whole run is at most some 28k cycles; margin kept under the cycle budget
   initial begin
      repeat (80000) @(posedge clk_sys);
      num_errors++;
      final_report();
   end
endmodule : tb_top
